// ### pg_seq_defs.vh
// Constants for the power-good and fault sequencer: timing, register map,
// field positions and reset values. Definitions only, no logic.
// Operation
// - Open-drain power-good pin is the wired-OR of all three outputs.
// - In run state power-good is released to high impedance while any output slews.
// - At startup power-good stays low until boot voltage, then 20us more.
// - Boot voltage code is captured when power-good first goes high.
// - Captured boot code clears on each rising edge of shutdown input.
// - Power-good is driven low during shutdown.
// - Skip mode blanks upper threshold in down slews till regulated.
// - Power-ok fall: power-good low during slew to boot code, then 20us.
// - Both high-side gate outputs are held low in shutdown.
// - Low-side gates low in shutdown, forced high on output overvoltage.
// - In skip mode low-side gate turns off after inductor zero crossing.
// - Thermal-fault pin pulls low while thermistor input is below 1.5V.
// - Thermal-fault output is high impedance during shutdown.
// - Supply lockout latches; cleared by power cycle or shutdown toggle.
// - Power-ok low after shutdown release: serial pins select boot code.
// - Later rising edge of power-ok leaves stored boot code unchanged.
`ifndef PG_SEQ_DEFS_VH
`define PG_SEQ_DEFS_VH

// Hold-off time and system clock
`define HOLD_TIME_NS    20000
`define CLK_PERIOD_NS   40
`define HOLD_CYCLES     ((`HOLD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Thermal trip point, realised by the analog comparator
`define THERM_TRIP_MV   1500
`define THERM_TRIP_PCT  30

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_BOOT        8'h08

// Control fields and reset value
`define CTRL_SKIP_LSB   0
`define CTRL_RESET      3'h0

// Status fields
`define ST_STATE_LSB    0
`define ST_PG_HIGH      3
`define ST_BOOTED       4
`define ST_UVLO         5
`define ST_HOT          6
`define ST_SHUT         7

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// ### pin_sync3.v
// Three-flop synchroniser for asynchronous pins and comparator outputs.
// Assumes nothing of its inputs; output follows once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter WIDTH = 1
)(
	// Clock and reset
	input  wire             clk_i,
	input  wire             nrst_i,
	// Pins
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] level_o
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	// Disagreeing bits keep their old level, which filters one-cycle glitches
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			stage1  <= {WIDTH{1'b0}};
			stage2  <= {WIDTH{1'b0}};
			stage3  <= {WIDTH{1'b0}};
			level_o <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1  <= async_i;
			stage2  <= stage1;
			stage3  <= stage2;
			level_o <= (stage2 & stage3) | (level_o & (stage2 ^ stage3));
		end
	end
endmodule // pin_sync3
`default_nettype wire

// ### holdoff_timer.v
// Hold-off counter for the power-good extension.
// Assumes start_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
module holdoff_timer #(
	parameter CYCLES = 500,
	parameter WIDTH  = 16
)(
	// Clock and reset
	input  wire clk_i,
	input  wire nrst_i,
	// Control
	input  wire start_i,
	output reg  expire_o
);
	localparam integer     LAST_I = CYCLES - 1;
	localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];

	reg [WIDTH-1:0] count;
	reg             running;

	// A new start reloads the count even mid-run
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			count    <= {WIDTH{1'b0}};
			running  <= 1'b0;
			expire_o <= 1'b0;
		end
		else if (start_i)
		begin
			count    <= LAST;
			running  <= 1'b1;
			expire_o <= 1'b0;
		end
		else if (running && count == {WIDTH{1'b0}})
		begin
			running  <= 1'b0;
			expire_o <= 1'b1;
		end
		else
		begin
			count    <= running ? count - 1'b1 : count;
			expire_o <= 1'b0;
		end
	end
endmodule // holdoff_timer
`default_nettype wire

// ### power_good_fault_sequencer.v
// Power-good, gate-drive override, thermal and lockout supervision.
// Assumes comparator outputs and pins are asynchronous; the slew controller
// and PWM requests run on CLK_SYS_I. Registers over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "pg_seq_defs.vh"
module power_good_fault_sequencer #(
	parameter HOLD_CYCLES = `HOLD_CYCLES
)(
	// Clock and reset
	input  wire        CLK_SYS_I,
	input  wire        NRST_I,
	// Host pins
	input  wire        SHUTDOWN_IN_N_I,
	input  wire        SYSTEM_POWER_OK_IN_I,
	input  wire        SERIAL_VID_CLOCK_PIN_I,
	input  wire        SERIAL_VID_DATA_PIN_I,
	// Analog comparators
	input  wire        THERMISTOR_SENSE_IN_I,
	input  wire        VCC_UVLO_I,
	input  wire [2:0]  REG_LOWER_OK_I,
	input  wire [2:0]  REG_UPPER_OVER_I,
	input  wire [1:0]  OVERVOLTAGE_I,
	input  wire [1:0]  ZERO_CROSS_I,
	// Slew controller
	input  wire [2:0]  SLEWING_I,
	input  wire [2:0]  SLEW_DOWN_I,
	input  wire        AT_BOOT_CODE_I,
	output reg         BOOT_SLEW_REQ_O,
	output reg  [1:0]  VOLTAGE_CODE_BOOT_O,
	// PWM requests
	input  wire [1:0]  HIGH_SIDE_REQ_I,
	input  wire [1:0]  LOW_SIDE_REQ_I,
	// Gate drives
	output reg         HIGH_SIDE_GATE_A_O,
	output reg         HIGH_SIDE_GATE_B_O,
	output reg         LOW_SIDE_GATE_A_O,
	output reg         LOW_SIDE_GATE_B_O,
	// Open-drain outputs
	output wire        POWER_GOOD_OUT_O,
	output reg         POWER_GOOD_OUT_OE_N_O,
	output wire        THERMAL_FAULT_OUT_N_O,
	output reg         THERMAL_FAULT_OUT_N_OE_N_O,
	// AXI4-Lite slave
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY
);
	localparam [2:0] ST_OFF   = 3'h0;
	localparam [2:0] ST_BOOT  = 3'h1;
	localparam [2:0] ST_HOLD  = 3'h2;
	localparam [2:0] ST_RUN   = 3'h3;
	localparam [2:0] ST_LSLEW = 3'h4;
	localparam [2:0] ST_LHOLD = 3'h5;

	function is_reg;
		input [7:0] addr;
		input [7:0] offset;
		begin
			is_reg = (addr[7:2] == offset[7:2]);
		end
	endfunction

	wire [15:0] sync_level;
	wire        shutdown_in_ok;
	wire        pok;
	wire [1:0]  serial_pins;
	wire        hot;
	wire        uvlo;
	wire [2:0]  lower_ok;
	wire [2:0]  upper_over;
	wire [1:0]  ovp;
	wire [1:0]  zc;

	pin_sync3 #(
		.WIDTH (16)
	) u_sync (
		.clk_i   (CLK_SYS_I),
		.nrst_i  (NRST_I),
		.async_i ({SHUTDOWN_IN_N_I, SYSTEM_POWER_OK_IN_I,
			SERIAL_VID_CLOCK_PIN_I, SERIAL_VID_DATA_PIN_I,
			THERMISTOR_SENSE_IN_I, VCC_UVLO_I, REG_LOWER_OK_I,
			REG_UPPER_OVER_I, OVERVOLTAGE_I, ZERO_CROSS_I}),
		.level_o (sync_level)
	);

	assign shutdown_in_ok     = sync_level[15];
	assign pok         = sync_level[14];
	assign serial_pins = sync_level[13:12];
	assign hot         = sync_level[11];
	assign uvlo        = sync_level[10];
	assign lower_ok    = sync_level[9:7];
	assign upper_over  = sync_level[6:4];
	assign ovp         = sync_level[3:2];
	assign zc          = sync_level[1:0];

	reg  [2:0] state;
	reg  [2:0] next_state;
	reg  [2:0] skip_mode;
	reg  [2:0] blank;
	reg        shutdown_in_prev;
	reg        pok_prev;
	reg        uvlo_latched;
	reg        booted;
	reg  [1:0] live_code;
	reg  [1:0] stored_code;
	reg  [1:0] zc_off;
	wire       hold_done;
	wire       shut;
	wire       slew_any;
	wire       pok_fall;
	wire       shutdown_in_toggle;
	wire [2:0] reg_good;
	wire       all_good;
	wire       pg_high;
	wire       hold_start;

	// Lockout acts like shutdown until cleared
	assign shut        = ~shutdown_in_ok | uvlo_latched;
	assign slew_any    = |SLEWING_I;
	assign pok_fall    = pok_prev & ~pok;
	assign shutdown_in_toggle = shutdown_in_ok ^ shutdown_in_prev;
	// Any regulator out of window pulls the shared pin low
	assign reg_good    = lower_ok & ~(upper_over & ~blank);
	assign all_good    = &reg_good;
	// Pin is also high while released for a slew
	assign pg_high     = (state == ST_RUN) & (all_good | slew_any);
	assign hold_start  = (next_state == ST_HOLD && state != ST_HOLD) ||
		(next_state == ST_LHOLD && state != ST_LHOLD);

	holdoff_timer #(
		.CYCLES (HOLD_CYCLES),
		.WIDTH  (16)
	) u_hold (
		.clk_i    (CLK_SYS_I),
		.nrst_i   (NRST_I),
		.start_i  (hold_start),
		.expire_o (hold_done)
	);

	always @*
	begin
		next_state = state;
		case (state)
			ST_OFF:
				next_state = ST_BOOT;
			ST_BOOT:
				if (AT_BOOT_CODE_I && !slew_any)
					next_state = ST_HOLD;
			ST_HOLD:
				if (hold_done)
					next_state = ST_RUN;
			ST_RUN:
				if (booted && pok_fall)
					next_state = ST_LSLEW;
			ST_LSLEW:
				if (AT_BOOT_CODE_I && !slew_any)
					next_state = ST_LHOLD;
			ST_LHOLD:
				if (pok_fall)
					next_state = ST_LSLEW;
				else if (hold_done)
					next_state = ST_RUN;
			default:
				next_state = ST_OFF;
		endcase
		if (shut)
			next_state = ST_OFF;
	end

	always @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			state        <= ST_OFF;
			shutdown_in_prev    <= 1'b0;
			pok_prev     <= 1'b0;
			uvlo_latched <= 1'b0;
			blank        <= 3'h0;
			zc_off       <= 2'h0;
		end
		else
		begin
			state     <= next_state;
			shutdown_in_prev <= shutdown_in_ok;
			pok_prev  <= pok;
			// Set wins over a toggle in the same cycle
			uvlo_latched <= (uvlo & shutdown_in_ok & (state != ST_OFF)) |
				(uvlo_latched & ~shutdown_in_toggle);
			blank <= (skip_mode & SLEWING_I & SLEW_DOWN_I) |
				(blank & ~(lower_ok & ~upper_over & ~SLEWING_I));
			// Sync delay of four cycles shortens the diode-free window
			zc_off <= {2{~shut}} & skip_mode[1:0] &
				(zc | (zc_off & ~HIGH_SIDE_REQ_I));
		end
	end

	// Boot select and capture
	always @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			live_code   <= 2'h0;
			stored_code <= 2'h0;
			booted      <= 1'b0;
		end
		else
		begin
			if (!shut && !pok && !booted)
				live_code <= serial_pins;
			if (shutdown_in_ok && !shutdown_in_prev)
			begin
				stored_code <= 2'h0;
				booted      <= 1'b0;
			end
			else if (pg_high && !booted)
			begin
				stored_code <= live_code;
				booted      <= 1'b1;
			end
		end
	end

	// Pins and gate drives
	assign POWER_GOOD_OUT_O      = 1'b0;
	assign THERMAL_FAULT_OUT_N_O = 1'b0;

	always @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			POWER_GOOD_OUT_OE_N_O      <= 1'b0;
			THERMAL_FAULT_OUT_N_OE_N_O <= 1'b1;
			BOOT_SLEW_REQ_O            <= 1'b0;
			VOLTAGE_CODE_BOOT_O        <= 2'h0;
			HIGH_SIDE_GATE_A_O         <= 1'b0;
			HIGH_SIDE_GATE_B_O         <= 1'b0;
			LOW_SIDE_GATE_A_O          <= 1'b0;
			LOW_SIDE_GATE_B_O          <= 1'b0;
		end
		else
		begin
			if (next_state != ST_RUN)
				POWER_GOOD_OUT_OE_N_O <= 1'b0;
			else if (slew_any)
				POWER_GOOD_OUT_OE_N_O <= 1'b1;
			else
				POWER_GOOD_OUT_OE_N_O <= all_good;
			THERMAL_FAULT_OUT_N_OE_N_O <= shut | ~hot;
			BOOT_SLEW_REQ_O     <= (next_state == ST_LSLEW);
			VOLTAGE_CODE_BOOT_O <= booted ? stored_code : live_code;
			HIGH_SIDE_GATE_A_O  <= ~shut & HIGH_SIDE_REQ_I[0];
			HIGH_SIDE_GATE_B_O  <= ~shut & HIGH_SIDE_REQ_I[1];
			LOW_SIDE_GATE_A_O   <= ~shut & (ovp[0] |
				(LOW_SIDE_REQ_I[0] & ~zc_off[0]));
			LOW_SIDE_GATE_B_O   <= ~shut & (ovp[1] |
				(LOW_SIDE_REQ_I[1] & ~zc_off[1]));
		end
	end

	// Register slave: write address and data are taken together
	wire       wr_take;
	wire       rd_take;
	reg [31:0] rd_word;

	assign wr_take       = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
	assign S_AXI_AWREADY = wr_take;
	assign S_AXI_WREADY  = wr_take;
	assign rd_take       = S_AXI_ARVALID & ~S_AXI_RVALID;
	assign S_AXI_ARREADY = rd_take;

	always @*
	begin
		rd_word = 32'h0000_0000;
		if (is_reg(S_AXI_ARADDR, `REG_CTRL))
			rd_word[2:0] = skip_mode;
		else if (is_reg(S_AXI_ARADDR, `REG_STATUS))
		begin
			rd_word[`ST_STATE_LSB+2:`ST_STATE_LSB] = state;
			rd_word[`ST_PG_HIGH] = pg_high;
			rd_word[`ST_BOOTED]  = booted;
			rd_word[`ST_UVLO]    = uvlo_latched;
			rd_word[`ST_HOT]     = hot;
			rd_word[`ST_SHUT]    = shut;
		end
		else if (is_reg(S_AXI_ARADDR, `REG_BOOT))
			rd_word[3:0] = {live_code, stored_code};
	end

	always @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			skip_mode    <= `CTRL_RESET;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `RESP_OKAY;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP  <= `RESP_OKAY;
			S_AXI_RDATA  <= 32'h0000_0000;
		end
		else
		begin
			if (wr_take)
			begin
				S_AXI_BVALID <= 1'b1;
				if (is_reg(S_AXI_AWADDR, `REG_CTRL))
				begin
					S_AXI_BRESP <= `RESP_OKAY;
					if (S_AXI_WSTRB[0])
						skip_mode <= S_AXI_WDATA[`CTRL_SKIP_LSB+2:`CTRL_SKIP_LSB];
				end
				else if (is_reg(S_AXI_AWADDR, `REG_STATUS) ||
					is_reg(S_AXI_AWADDR, `REG_BOOT))
					S_AXI_BRESP <= `RESP_OKAY;
				else
					S_AXI_BRESP <= `RESP_DECERR;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
			if (rd_take)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_word;
				if (is_reg(S_AXI_ARADDR, `REG_CTRL) ||
					is_reg(S_AXI_ARADDR, `REG_STATUS) ||
					is_reg(S_AXI_ARADDR, `REG_BOOT))
					S_AXI_RRESP <= `RESP_OKAY;
				else
					S_AXI_RRESP <= `RESP_DECERR;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
endmodule // power_good_fault_sequencer
`default_nettype wire

// ### pg_seq_chk.sv
// Port checker of the power-good sequencer, bound to its top module.
// Assumes one clock; pins settle within six edges of a change.
`timescale 1ns/1ns
`default_nettype none
module pg_seq_chk #(
	parameter HOLD_CYCLES = 8
)(
	// Clock and reset
	input wire       CLK_SYS_I,
	input wire       NRST_I,
	// Pins and comparators
	input wire       SHUTDOWN_IN_N_I,
	input wire       THERMISTOR_SENSE_IN_I,
	input wire       VCC_UVLO_I,
	input wire [1:0] OVERVOLTAGE_I,
	// Outputs watched
	input wire       BOOT_SLEW_REQ_O,
	input wire [1:0] VOLTAGE_CODE_BOOT_O,
	input wire       HIGH_SIDE_GATE_A_O,
	input wire       LOW_SIDE_GATE_A_O,
	input wire       POWER_GOOD_OUT_O,
	input wire       POWER_GOOD_OUT_OE_N_O,
	input wire       THERMAL_FAULT_OUT_N_OE_N_O
);
	logic [15:0] run_cnt;
	logic [3:0]  shut_cnt;
	logic [3:0]  hot_cnt;
	logic [3:0]  cold_cnt;
	logic [3:0]  ov_cnt;
	logic        uv;
	wire         shut = shut_cnt > 4'h5;
	wire         run  = run_cnt > 16'h0005 && !uv;
	function automatic logic [3:0] sat(input logic [3:0] c, input logic b);
		sat = b ? c + {3'h0, c != 4'hf} : 4'h0;
	endfunction
	// Levels count only once held past the synchroniser delay
	always @(posedge CLK_SYS_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			run_cnt  <= 16'h0000;
			shut_cnt <= 4'h0;
			hot_cnt  <= 4'h0;
			cold_cnt <= 4'h0;
			ov_cnt   <= 4'h0;
			uv       <= 1'b0;
		end
		else
		begin
			run_cnt  <= SHUTDOWN_IN_N_I ? run_cnt + {15'h0, ~&run_cnt} : 16'h0;
			shut_cnt <= sat(shut_cnt, !SHUTDOWN_IN_N_I);
			hot_cnt  <= sat(hot_cnt, THERMISTOR_SENSE_IN_I);
			cold_cnt <= sat(cold_cnt, !THERMISTOR_SENSE_IN_I);
			ov_cnt   <= sat(ov_cnt, OVERVOLTAGE_I[0]);
			// Pessimistic: a lockout is assumed until a long shutdown
			uv       <= VCC_UVLO_I | (uv & (shut_cnt != 4'h8));
		end
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);
	AST_OD_DATA: assert property (!POWER_GOOD_OUT_O)
		else $error("power-good data not low");
	AST_SHUT_PG: assert property (shut |-> !POWER_GOOD_OUT_OE_N_O)
		else $error("power-good released in shutdown");
	AST_SHUT_HS: assert property (shut |-> !HIGH_SIDE_GATE_A_O)
		else $error("high-side gate on in shutdown");
	AST_SHUT_LS: assert property (shut |-> !LOW_SIDE_GATE_A_O)
		else $error("low-side gate on in shutdown");
	AST_SHUT_HOT: assert property (shut |-> THERMAL_FAULT_OUT_N_OE_N_O)
		else $error("thermal output driven in shutdown");
	AST_HOLD: assert property ($rose(POWER_GOOD_OUT_OE_N_O) |->
		run_cnt > HOLD_CYCLES) else $error("power-good released too early");
	AST_HOT: assert property (hot_cnt > 4'h5 && run |->
		!THERMAL_FAULT_OUT_N_OE_N_O) else $error("hot not flagged");
	AST_COLD: assert property (cold_cnt > 4'h5 |->
		THERMAL_FAULT_OUT_N_OE_N_O) else $error("cold flagged hot");
	AST_OVP: assert property (ov_cnt > 4'h5 && run |->
		LOW_SIDE_GATE_A_O) else $error("overvoltage did not force low side");
	AST_CODE: assert property (POWER_GOOD_OUT_OE_N_O [*3] |=>
		$stable(VOLTAGE_CODE_BOOT_O)) else $error("stored code moved");
	AST_LOSS: assert property (BOOT_SLEW_REQ_O && $past(BOOT_SLEW_REQ_O)
		|-> !POWER_GOOD_OUT_OE_N_O) else $error("power-good up in boot slew");
endmodule // pg_seq_chk
bind power_good_fault_sequencer pg_seq_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
	.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .SHUTDOWN_IN_N_I(SHUTDOWN_IN_N_I),
	.THERMISTOR_SENSE_IN_I(THERMISTOR_SENSE_IN_I), .VCC_UVLO_I(VCC_UVLO_I),
	.OVERVOLTAGE_I(OVERVOLTAGE_I), .BOOT_SLEW_REQ_O(BOOT_SLEW_REQ_O),
	.VOLTAGE_CODE_BOOT_O(VOLTAGE_CODE_BOOT_O),
	.HIGH_SIDE_GATE_A_O(HIGH_SIDE_GATE_A_O),
	.LOW_SIDE_GATE_A_O(LOW_SIDE_GATE_A_O), .POWER_GOOD_OUT_O(POWER_GOOD_OUT_O),
	.POWER_GOOD_OUT_OE_N_O(POWER_GOOD_OUT_OE_N_O),
	.THERMAL_FAULT_OUT_N_OE_N_O(THERMAL_FAULT_OUT_N_OE_N_O));
`default_nettype wire

// ### pg_host_model.sv
// Host power sequencing: drives shutdown and system power-ok.
// Assumes commands change just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module pg_host_model (
	input  wire  clk_i,
	input  wire  run_i,
	input  wire  lose_i,
	input  wire  pg_wire_i,
	output logic shutdown_in_n_o,
	output logic pok_o
);
	initial
	begin
		shutdown_in_n_o = 1'b0;
		pok_o    = 1'b0;
	end
	// Power-ok waits for the pulled-up wire, so boot select stays live
	always @(posedge clk_i)
	begin
		shutdown_in_n_o <= run_i;
		pok_o    <= run_i & ~lose_i & (pok_o | pg_wire_i);
	end
endmodule // pg_host_model
`default_nettype wire

// ### power_good_fault_sequencer_bench.sv
// Self-checking bench of the power-good sequencer with a host model.
// Assumes the hold-off is shortened to eight cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pg_seq_defs.vh"
module power_good_fault_sequencer_bench;
	localparam HOLD = 8;
	localparam S    = 10;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        run = 1'b0;
	logic        lose = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [1:0]  boot;
	logic        hot = 1'b0;
	logic        uvlo = 1'b0;
	logic [2:0]  low_ok = 3'h7;
	logic [2:0]  slewing = 3'h0;
	logic        at_boot = 1'b0;
	logic [1:0]  ov = 2'h0;
	logic [1:0]  zc = 2'h0;
	logic [2:0]  up_ov = 3'h0;
	logic [2:0]  down = 3'h0;
	logic [1:0]  hs_req = 2'h0;
	logic [1:0]  ls_req = 2'h0;
	logic [7:0]  awaddr = 8'h0;
	logic [7:0]  araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	wire         awready, wready, arready, bvalid, rvalid;
	wire  [1:0]  bresp, rresp, code;
	wire  [31:0] rdata;
	wire  [3:0]  gate;
	wire         shutdown_in_n, pok, slew_req, pg_oe_n, hot_oe_n, pg_data, hot_data;
	wire         pg_wire = pg_oe_n ? 1'b1 : pg_data;
	logic [31:0] rd_d;
	logic [1:0]  rd_r;
	logic [1:0]  wr_r;
	logic [31:0] ctrl_v;
	int          bad_count = 0;
	int          checked = 0;
	int          n;
	always #20 clk = ~clk;
	pg_host_model host_u (.clk_i(clk), .run_i(run), .lose_i(lose),
		.pg_wire_i(pg_wire), .shutdown_in_n_o(shutdown_in_n), .pok_o(pok));
	power_good_fault_sequencer #(.HOLD_CYCLES(HOLD)) dut_u (
		.CLK_SYS_I(clk), .NRST_I(nrst), .SHUTDOWN_IN_N_I(shutdown_in_n),
		.SYSTEM_POWER_OK_IN_I(pok), .SERIAL_VID_CLOCK_PIN_I(sel[1]),
		.SERIAL_VID_DATA_PIN_I(sel[0]), .THERMISTOR_SENSE_IN_I(hot),
		.VCC_UVLO_I(uvlo), .REG_LOWER_OK_I(low_ok), .REG_UPPER_OVER_I(up_ov),
		.OVERVOLTAGE_I(ov), .ZERO_CROSS_I(zc), .SLEWING_I(slewing),
		.SLEW_DOWN_I(down), .AT_BOOT_CODE_I(at_boot),
		.BOOT_SLEW_REQ_O(slew_req), .VOLTAGE_CODE_BOOT_O(code),
		.HIGH_SIDE_REQ_I(hs_req), .LOW_SIDE_REQ_I(ls_req),
		.HIGH_SIDE_GATE_A_O(gate[0]), .HIGH_SIDE_GATE_B_O(gate[1]),
		.LOW_SIDE_GATE_A_O(gate[2]), .LOW_SIDE_GATE_B_O(gate[3]),
		.POWER_GOOD_OUT_O(pg_data), .POWER_GOOD_OUT_OE_N_O(pg_oe_n),
		.THERMAL_FAULT_OUT_N_O(hot_data), .THERMAL_FAULT_OUT_N_OE_N_O(hot_oe_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// Gates follow the requests when no override applies
	function automatic logic [3:0] gate_exp(input logic [1:0] h,
		input logic [1:0] l);
		gate_exp = {l, h};
	endfunction
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		wr_r = bresp;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		rd_d = rdata;
		rd_r = rresp;
		@(posedge clk);
	endtask
	// Cycles from the boot code being reached to the wire going high
	task wait_pg;
		n = 0;
		while (pg_wire !== 1'b1 && n < 500)
		begin
			@(posedge clk);
			n++;
		end
		chk("hold", 1, n >= HOLD && n <= HOLD + 8);
	endtask
	task end_of_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		cyc(50000);
		bad_count++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(26));
		cyc(2);
		nrst <= 1'b1;
		cyc(2);
		chk("pg_reset", 0, pg_wire);
		chk("gate_reset", 0, gate);
		chk("hot_reset", 1, hot_oe_n);
		chk("hot_data", 0, hot_data);
		$display("test reset done");
		sel <= 2'($urandom % 3);
		run <= 1'b1;
		cyc(S);
		chk("live", sel, code);
		sel <= ~sel;
		cyc(S);
		chk("live2", sel, code);
		boot = sel;
		at_boot <= 1'b1;
		wait_pg();
		cyc(3);
		sel <= ~sel;
		cyc(S);
		chk("stored", boot, code);
		at_boot <= 1'b0;
		lose <= 1'b1;
		cyc(S);
		chk("boot_slew", 1, slew_req);
		chk("pg_loss", 0, pg_wire);
		at_boot <= 1'b1;
		wait_pg();
		lose <= 1'b0;
		cyc(S);
		chk("stored2", boot, code);
		$display("test boot done");
		slewing <= 3'h1;
		low_ok <= 3'h6;
		cyc(S);
		chk("slew_released", 1, pg_wire);
		low_ok <= 3'h7;
		cyc(S);
		slewing <= 3'h0;
		repeat (16)
		begin
			hs_req <= 2'($urandom);
			ls_req <= 2'($urandom);
			cyc(2);
			chk("gates", gate_exp(hs_req, ls_req), gate);
		end
		hs_req <= 2'h0;
		ls_req <= 2'h0;
		ov <= 2'h3;
		cyc(S);
		chk("ovp", 2'h3, gate[3:2]);
		ov <= 2'h0;
		wr(`REG_CTRL, 32'h1);
		chk("bresp", `RESP_OKAY, wr_r);
		ls_req <= 2'h3;
		zc <= 2'h3;
		cyc(S);
		chk("zc_skip", 0, gate[2]);
		chk("zc_forced", 1, gate[3]);
		zc <= 2'h0;
		slewing <= 3'h1;
		down <= 3'h1;
		up_ov <= 3'h1;
		cyc(S);
		slewing <= 3'h0;
		down <= 3'h0;
		cyc(S);
		chk("blank_held", 1, pg_wire);
		up_ov <= 3'h0;
		cyc(S);
		up_ov <= 3'h1;
		cyc(S);
		chk("blank_rearm", 0, pg_wire);
		up_ov <= 3'h0;
		ctrl_v = $urandom & 32'h7;
		wr(`REG_CTRL, ctrl_v);
		rd(`REG_CTRL);
		chk("ctrl", ctrl_v, rd_d);
		hot <= 1'b1;
		cyc(S);
		chk("hot", 0, hot_oe_n);
		hot <= 1'b0;
		cyc(S);
		chk("cold", 1, hot_oe_n);
		$display("test gates done");
		uvlo <= 1'b1;
		cyc(S);
		uvlo <= 1'b0;
		cyc(S);
		rd(`REG_STATUS);
		chk("uvlo_held", 1, rd_d[`ST_UVLO]);
		chk("uvlo_gate", 0, gate);
		hot <= 1'b1;
		run <= 1'b0;
		at_boot <= 1'b0;
		cyc(S);
		chk("pg_shut", 0, pg_wire);
		chk("hot_shut", 1, hot_oe_n);
		chk("gate_shut", 0, gate);
		hot <= 1'b0;
		run <= 1'b1;
		cyc(S);
		rd(`REG_BOOT);
		chk("boot_clear", 0, rd_d[1:0]);
		rd(`REG_STATUS);
		chk("uvlo_clear", 0, rd_d[`ST_UVLO]);
		rd(8'h0c);
		chk("unmapped", `RESP_DECERR, rd_r);
		$display("test shutdown done");
		end_of_test();
	end
endmodule // power_good_fault_sequencer_bench
`default_nettype wire
